/* File: rtl/iomb_pkg.sv */
package iomb_pkg;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int unsigned PORT_COUNT = 4;
  localparam int unsigned CHIP_COUNT = 2;
  localparam int unsigned APB_ADDR_W = 12;

  // ---------------------------------------------------------------------
  // apb register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [11:0] REG_CFG_OFF = 12'h000;
  localparam logic [11:0] REG_PORT_OFF = 12'h004;
  localparam logic [11:0] REG_STAT_OFF = 12'h008;

  // ---------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PORT_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  // address-switch register: page, bank enable, bank select
  localparam int unsigned CFG_PAGE_LSB = 0;
  localparam int unsigned CFG_BANKEN_BIT = 8;
  localparam int unsigned CFG_BANKSEL_BIT = 9;
  // port-switch register: direction, programmed select, jumpers
  localparam int unsigned PCFG_DIR_LSB = 0;
  localparam int unsigned PCFG_PROG_LSB = 4;
  localparam int unsigned PCFG_C2J_LSB = 8;
  localparam int unsigned PCFG_C1J_LSB = 12;
  // status register
  localparam int unsigned STAT_DIR_LSB = 0;
  localparam int unsigned STAT_SEL_BIT = 4;
  localparam int unsigned STAT_IRQ_BIT = 5;
  localparam int unsigned STAT_RST_BIT = 6;
  localparam int unsigned STAT_CHIP_LSB = 8;

  // bank decode: bank 1 is chosen by a low bank line
  localparam logic BANK_UPPER = 1'b1;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic bankSelect;
    logic bankEnable;
    logic [7:0] basePage;
  } iomb_cfg_t;

  typedef struct packed {
    logic [1:0] ctrl1JumperB;
    logic [3:0] ctrl2Jumper;
    logic [3:0] progSelect;
    logic [3:0] dirSwitch;
  } iomb_port_cfg_t;

  typedef struct packed {
    logic [15:0] addrN;
    logic bankN;
    logic rwN;
    logic phi2N;
    logic resetN;
    logic [7:0] dataN;
    logic [1:0] chipIrqN;
    logic [15:0] chipRdData;
    logic [3:0] secondCtrl;
  } iomb_pins_t;

endpackage

/* File: rtl/iomb_bus_glue.sv */
`timescale 1ns/1ps

// Function
// - bus active low exactly while transceivers enabled
// - high bank line bank 0, low bank 1
// - read with low read_write_n drives backplane
// - high read_write_n drives chips, passed through
// - select only in low phase-two-not half
// - bus reset passed to both chips
// - interrupt low when either chip requests
// - port direction from switch, select, control two
// - one direction bit per whole port
// - port A first control buffer always input
// - port B first control follows jumper
// - second control buffers follow jumpers
// - programmed mode: control two steers direction
// - one page, base on any page boundary
// - 32 locations, 16 per chip
// - upper in-page bits ignored, mirrors
// - connectors map chip1 A,B then chip2 A,B
// - bits 15:8 page, 3:0 register, 4 chip
// - bank enable: both banks or selected bank
// - control two high output, low input
// - reset forces programmed ports to output
module iomb_bus_glue #(
  parameter int unsigned PORTS = iomb_pkg::PORT_COUNT
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // apb register port
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // backplane side
  input wire logic [15:0] backplane_address_n,
  input wire logic bank_address_n,
  input wire logic read_write_n,
  input wire logic phase_two_clock_n,
  input wire logic bus_reset_n,
  input wire logic [7:0] backplane_data_n_rd,
  output logic [7:0] backplane_data_n_drv,
  output logic backplane_data_n_en_n,
  output logic bus_active_n,
  output logic interrupt_request_n,
  // adapter chip side
  input wire logic [15:0] chipRdData,
  input wire logic [1:0] chipIrqN,
  output logic [7:0] chipWrData,
  output logic chipDataEnN,
  output logic [1:0] chipSelect,
  output logic [3:0] chipRegSelect,
  output logic chipReadWriteN,
  output logic chipResetN,
  // second control lines, one pair per chip
  input wire logic [1:0] port_a_second_control,
  input wire logic [1:0] port_b_second_control,
  // buffer directions, 1 = toward the peripheral
  output logic [3:0] portDataDir,
  output logic [1:0] portAFirstControlDir,
  output logic [1:0] portBFirstControlDir,
  output logic [1:0] portASecondControlDir,
  output logic [1:0] portBSecondControlDir
);

  // -----------------------------------------------------------------------
  // parameter check
  // -----------------------------------------------------------------------
  // connector mapping and the chip count are wired for four ports
  if (PORTS != 4) begin : gBadPorts
    $error("iomb_bus_glue supports exactly four ports");
  end

  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  iomb_pkg::iomb_pins_t pinRaw;
  iomb_pkg::iomb_pins_t pinMeta_reg;
  iomb_pkg::iomb_pins_t pinSync_reg;

  // connector order: chip1 A, chip1 B, chip2 A, chip2 B
  always_comb begin
    pinRaw.addrN = backplane_address_n;
    pinRaw.bankN = bank_address_n;
    pinRaw.rwN = read_write_n;
    pinRaw.phi2N = phase_two_clock_n;
    pinRaw.resetN = bus_reset_n;
    pinRaw.dataN = backplane_data_n_rd;
    pinRaw.chipIrqN = chipIrqN;
    pinRaw.chipRdData = chipRdData;
    pinRaw.secondCtrl = {port_b_second_control[1], port_a_second_control[1],
                         port_b_second_control[0], port_a_second_control[0]};
  end

  // two stages; only the second stage is read by logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_reg <= '1;
      pinSync_reg <= '1;
    end else if (ce) begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // -----------------------------------------------------------------------
  // switch and jumper registers
  // -----------------------------------------------------------------------
  iomb_pkg::iomb_cfg_t cfg;
  iomb_pkg::iomb_port_cfg_t pcfg;
  logic [31:0] cfgWord_reg;
  logic [31:0] portWord_reg;
  logic [31:0] statWord;
  logic [31:0] byteMask;
  logic apbSetup;
  logic apbWrite;
  logic hitCfg;
  logic hitPort;
  logic hitStat;

  assign cfg = iomb_pkg::iomb_cfg_t'(cfgWord_reg[9:0]);
  assign pcfg = iomb_pkg::iomb_port_cfg_t'(portWord_reg[13:0]);

  // byte enables widened to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byteMask[b*8 +: 8] = {8{pstrb[b]}};
    end
  end

  assign apbSetup = psel && penable && !pready;
  assign apbWrite = psel && penable && pready && pwrite;
  assign hitCfg = (paddr == iomb_pkg::REG_CFG_OFF);
  assign hitPort = (paddr == iomb_pkg::REG_PORT_OFF);
  assign hitStat = (paddr == iomb_pkg::REG_STAT_OFF);

  // page, bank enable and bank select; unused bits stay zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgWord_reg <= iomb_pkg::CFG_RST;
    end else if (ce && apbWrite && hitCfg) begin
      cfgWord_reg <= ((cfgWord_reg & ~byteMask) | (pwdata & byteMask))
                     & 32'h0000_03FF;
    end
  end

  // direction switches, programmed selects and jumpers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      portWord_reg <= iomb_pkg::PORT_RST;
    end else if (ce && apbWrite && hitPort) begin
      portWord_reg <= ((portWord_reg & ~byteMask) | (pwdata & byteMask))
                      & 32'h0000_3FFF;
    end
  end

  // -----------------------------------------------------------------------
  // apb answer
  // -----------------------------------------------------------------------
  // one wait state; read data registered so outputs come from flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= apbSetup;
      pslverr <= apbSetup && !(hitCfg || hitPort || hitStat);
      if (apbSetup && !pwrite) begin
        if (hitCfg) begin
          prdata <= cfgWord_reg;
        end else if (hitPort) begin
          prdata <= portWord_reg;
        end else if (hitStat) begin
          prdata <= statWord;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------------------------------------
  // address and bank decode
  // -----------------------------------------------------------------------
  logic upperBank;
  logic bankOk;
  logic pageHit;
  logic selNow;
  logic readNow;
  logic writeNow;
  logic resetting;

  // a low bank line addresses bank 1
  assign upperBank = !pinSync_reg.bankN;
  // enable clear: both banks; set: only the switch's bank
  assign bankOk = !cfg.bankEnable ||
                  (upperBank == (cfg.bankSelect == iomb_pkg::BANK_UPPER));
  // page compare on bits 15:8; bits 7:5 never looked at
  assign pageHit = (~pinSync_reg.addrN[15:8] == cfg.basePage);
  // only during the low half of phase-two-not
  assign selNow = bankOk && pageHit && !pinSync_reg.phi2N;
  assign readNow = selNow && !pinSync_reg.rwN;
  assign writeNow = selNow && pinSync_reg.rwN;
  assign resetting = !pinSync_reg.resetN;

  // -----------------------------------------------------------------------
  // chip access
  // -----------------------------------------------------------------------
  // bit 4 picks the chip, bits 3:0 the register: 2 x 16 locations
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chipSelect <= 2'b00;
      chipRegSelect <= 4'h0;
      chipReadWriteN <= 1'b1;
    end else if (ce) begin
      chipSelect[0] <= selNow && pinSync_reg.addrN[4];
      chipSelect[1] <= selNow && !pinSync_reg.addrN[4];
      chipRegSelect <= ~pinSync_reg.addrN[3:0];
      chipReadWriteN <= pinSync_reg.rwN;
    end
  end

  // transceivers and bus active move together, so they never disagree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_active_n <= 1'b1;
      backplane_data_n_en_n <= 1'b1;
      chipDataEnN <= 1'b1;
    end else if (ce) begin
      bus_active_n <= !selNow;
      backplane_data_n_en_n <= !readNow;
      chipDataEnN <= !writeNow;
    end
  end

  // data steering; the backplane carries inverted data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      backplane_data_n_drv <= 8'hFF;
      chipWrData <= 8'h00;
    end else if (ce) begin
      backplane_data_n_drv <= pinSync_reg.addrN[4] ?
                              ~pinSync_reg.chipRdData[7:0] :
                              ~pinSync_reg.chipRdData[15:8];
      chipWrData <= ~pinSync_reg.dataN;
    end
  end

  // -----------------------------------------------------------------------
  // reset and interrupt pass-through
  // -----------------------------------------------------------------------
  // timers and shifter inside the chips ignore it; that is theirs to do
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chipResetN <= 1'b0;
      interrupt_request_n <= 1'b1;
    end else if (ce) begin
      chipResetN <= pinSync_reg.resetN;
      interrupt_request_n <= &pinSync_reg.chipIrqN;
    end
  end

  // -----------------------------------------------------------------------
  // port buffer directions
  // -----------------------------------------------------------------------
  // one bit per port: the buffers cannot split a port bit by bit
  for (genvar p = 0; p < 4; p++) begin : gPortDir
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        portDataDir[p] <= 1'b0;
      end else if (ce) begin
        if (pcfg.progSelect[p]) begin
          // reset releases control two high, so the port turns output
          portDataDir[p] <= resetting || pinSync_reg.secondCtrl[p];
        end else begin
          portDataDir[p] <= pcfg.dirSwitch[p];
        end
      end
    end
  end

  // control-line buffers: port A first control fixed input, the rest follow jumpers only; reset leaves them alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      portAFirstControlDir <= 2'b00;
      portBFirstControlDir <= 2'b00;
      portASecondControlDir <= 2'b00;
      portBSecondControlDir <= 2'b00;
    end else if (ce) begin
      portAFirstControlDir <= 2'b00;
      portBFirstControlDir <= pcfg.ctrl1JumperB;
      portASecondControlDir <= {pcfg.ctrl2Jumper[2],
                                pcfg.ctrl2Jumper[0]};
      portBSecondControlDir <= {pcfg.ctrl2Jumper[3],
                                pcfg.ctrl2Jumper[1]};
    end
  end

  // -----------------------------------------------------------------------
  // status word
  // -----------------------------------------------------------------------
  always_comb begin
    statWord = 32'h0000_0000;
    statWord[iomb_pkg::STAT_DIR_LSB +: 4] = portDataDir;
    statWord[iomb_pkg::STAT_SEL_BIT] = !bus_active_n;
    statWord[iomb_pkg::STAT_IRQ_BIT] = !interrupt_request_n;
    statWord[iomb_pkg::STAT_RST_BIT] = resetting;
    statWord[iomb_pkg::STAT_CHIP_LSB +: 2] = chipSelect;
  end

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  a_active_tracks_xcvr: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_active_n == (backplane_data_n_en_n && chipDataEnN))
    else $error("bus active disagrees with transceiver enables");

  a_read_drives_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && readNow) |=> (!backplane_data_n_en_n && !chipReadWriteN))
    else $error("read did not drive the backplane");

  a_write_drives_chip: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && writeNow) |=> (!chipDataEnN && backplane_data_n_en_n))
    else $error("write did not drive the chips");

  a_phase_gates_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && pinSync_reg.phi2N) |=> (chipSelect == 2'b00 && bus_active_n))
    else $error("select outside the low clock phase");

  a_reset_passes: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce |=> chipResetN == $past(pinSync_reg.resetN))
    else $error("bus reset not passed to chips");

  a_irq_merge: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && pinSync_reg.chipIrqN != 2'b11) |=> !interrupt_request_n)
    else $error("chip interrupt not merged");

  a_one_chip_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    $onehot0(chipSelect) && (chipSelect == 2'b00 || !bus_active_n))
    else $error("bad chip select");

  a_porta_c1_input: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 portAFirstControlDir == 2'b00)
    else $error("port A first control not input");

  a_reset_prog_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && resetting) |=> ((portDataDir & $past(pcfg.progSelect))
                           == $past(pcfg.progSelect)))
    else $error("programmed port not output in reset");

  a_reg_mirror: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && selNow) |=> chipRegSelect == ~$past(pinSync_reg.addrN[3:0]))
    else $error("register select wrong");

  a_apb_one_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && apbSetup) |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule // iomb_bus_glue

/* File: tb/iomb_host_model.sv */
`timescale 1ns/1ps

module iomb_host_model (
  // clock
  input wire logic core_clk,
  // backplane lines driven by the host, all active low
  output logic [15:0] addrN = 16'hffff,
  output logic bankN = 1'b1,
  output logic rwN = 1'b1,
  output logic phi2N = 1'b1,
  output logic resetN = 1'b1,
  output logic [7:0] dataN = 8'hff
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // bank line is settled one cycle ahead of the access that uses it
  task automatic drive(input logic [15:0] a, input logic bank1,
      input logic rd, input logic [7:0] d, input logic lowPhase);
    @(posedge core_clk);
    bankN <= ~bank1;
    @(posedge core_clk);
    addrN <= ~a;
    rwN <= ~rd;
    dataN <= ~d;
    phi2N <= ~lowPhase;
  endtask

  // released lines show the inverse so a stale value never passes
  task automatic release_bus();
    @(posedge core_clk);
    phi2N <= 1'b1;
    rwN <= 1'b1;
    addrN <= ~addrN;
    dataN <= ~dataN;
  endtask

  // bus reset level
  task automatic set_reset(input logic active);
    @(posedge core_clk);
    resetN <= ~active;
  endtask
endmodule // iomb_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic [15:0] addrN;
  wire logic bankN, rwN, phi2N, resetN;
  wire logic [7:0] hostDataN;
  wire logic [7:0] busData;
  logic [7:0] drv, chipWrData;
  logic enN, busActN, irqN, chipDataEnN, chipReadWriteN, chipResetN;
  logic [15:0] chipRdData = 16'ha55a;
  logic [1:0] chipIrqN = 2'b11;
  logic [1:0] secA = 2'b11;
  logic [1:0] secB = 2'b11;
  logic [1:0] chipSelect, aFirst, bFirst, aSecond, bSecond;
  logic [3:0] chipRegSelect, portDataDir;
  int miscompares = 0;
  int testsRun = 0;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // shared data line: the glue wins only while its enable is low
  assign busData = (enN === 1'b0) ? drv : hostDataN;

  iomb_host_model HOST (.core_clk(core_clk), .addrN(addrN),
    .bankN(bankN), .rwN(rwN), .phi2N(phi2N), .resetN(resetN),
    .dataN(hostDataN));

  iomb_bus_glue #(.PORTS(4)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .backplane_address_n(addrN),
    .bank_address_n(bankN), .read_write_n(rwN),
    .phase_two_clock_n(phi2N), .bus_reset_n(resetN),
    .backplane_data_n_rd(busData), .backplane_data_n_drv(drv),
    .backplane_data_n_en_n(enN), .bus_active_n(busActN),
    .interrupt_request_n(irqN), .chipRdData(chipRdData),
    .chipIrqN(chipIrqN), .chipWrData(chipWrData),
    .chipDataEnN(chipDataEnN), .chipSelect(chipSelect),
    .chipRegSelect(chipRegSelect), .chipReadWriteN(chipReadWriteN),
    .chipResetN(chipResetN), .port_a_second_control(secA),
    .port_b_second_control(secB), .portDataDir(portDataDir),
    .portAFirstControlDir(aFirst), .portBFirstControlDir(bFirst),
    .portASecondControlDir(aSecond), .portBSecondControlDir(bSecond));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
        exp);
    end
  endtask

  // one apb transfer; waits for pready with a bound
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // pready, read data and error are taken at the completing edge
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: no bus answer", $time);
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
      input logic expErr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, expErr}, "error response");
  endtask

  // pin changes need three edges to reach the outputs
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // decode state: active, read enable, write enable, rw, selects
  task automatic bus(input logic [9:0] exp, input string what);
    chk({22'h0, busActN, enN, chipDataEnN, chipReadWriteN, chipSelect,
      chipRegSelect}, {22'h0, exp}, what);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_regs();
    rd(iomb_pkg::REG_CFG_OFF, 32'h0000_0000, 1'b0);
    rd(iomb_pkg::REG_PORT_OFF, 32'h0000_0000, 1'b0);
    rd(12'h00c, 32'h0000_0000, 1'b1);
    $display("test regs done");
  endtask

  task automatic test_decode();
    wr(iomb_pkg::REG_CFG_OFF, 32'h0000_0012);
    HOST.drive(16'h1205, 1'b0, 1'b1, 8'h00, 1'b1);
    settle();
    bus({1'b0, 1'b0, 1'b1, 1'b0, 2'b01, 4'h5}, "read");
    chk({24'h0, drv}, 32'h0000_00a5, "read data out");
    rd(iomb_pkg::REG_STAT_OFF, 32'h0000_0110, 1'b0);
    HOST.release_bus();
    HOST.drive(16'h12f3, 1'b0, 1'b1, 8'h00, 1'b1);
    settle();
    bus({1'b0, 1'b0, 1'b1, 1'b0, 2'b10, 4'h3}, "mirror");
    chk({24'h0, drv}, 32'h0000_005a, "chip two data");
    HOST.release_bus();
    HOST.drive(16'h1207, 1'b0, 1'b0, 8'h3c, 1'b1);
    settle();
    bus({1'b0, 1'b1, 1'b0, 1'b1, 2'b01, 4'h7}, "write");
    chk({24'h0, chipWrData}, 32'h0000_003c, "write data");
    HOST.release_bus();
    HOST.drive(16'h1305, 1'b0, 1'b1, 8'h00, 1'b1);
    settle();
    bus({1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 4'h5}, "wrong page");
    HOST.release_bus();
    HOST.drive(16'h1205, 1'b0, 1'b1, 8'h00, 1'b0);
    settle();
    bus({1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 4'h5}, "high phase");
    HOST.release_bus();
    $display("test decode done");
  endtask

  task automatic test_bank();
    // {expect selected, bank one, address switches}
    logic [11:0] c [6] = '{12'hf12, 12'h312, 12'ha12, 12'he12, 12'h912,
      12'h512};
    foreach (c[i]) begin
      wr(iomb_pkg::REG_CFG_OFF, {22'h0, c[i][9:0]});
      HOST.drive(16'h1205, c[i][10], 1'b1, 8'h00, 1'b1);
      settle();
      chk({31'h0, busActN}, {31'h0, ~c[i][11]}, "bank");
      HOST.release_bus();
    end
    $display("test bank done");
  endtask

  task automatic test_irq();
    // enable low: a chip request must not reach the bus line
    @(posedge core_clk);
    ce <= 1'b0;
    chipIrqN <= 2'b00;
    settle();
    chk({31'h0, irqN}, 32'h0000_0001, "frozen interrupt");
    @(posedge core_clk);
    ce <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      chipIrqN <= i[1:0];
      settle();
      chk({31'h0, irqN}, {31'h0, &i[1:0]}, "interrupt");
    end
    $display("test irq done");
  endtask

  task automatic test_ports();
    @(posedge core_clk);
    secA <= 2'b01;
    secB <= 2'b10;
    wr(iomb_pkg::REG_PORT_OFF, 32'h0000_2605);
    settle();
    chk({20'h0, portDataDir, aFirst, bFirst, aSecond, bSecond},
      {20'h0, 4'b0101, 2'b00, 2'b10, 2'b10, 2'b01}, "manual");
    rd(iomb_pkg::REG_PORT_OFF, 32'h0000_2605, 1'b0);
    wr(iomb_pkg::REG_PORT_OFF, 32'h0000_26f5);
    settle();
    chk({28'h0, portDataDir}, 32'h0000_0009, "programmed");
    HOST.set_reset(1'b1);
    settle();
    chk({28'h0, portDataDir}, 32'h0000_000f, "reset dirs");
    chk({31'h0, chipResetN}, 32'h0000_0000, "chip reset");
    rd(iomb_pkg::REG_STAT_OFF, 32'h0000_004f, 1'b0);
    wr(iomb_pkg::REG_PORT_OFF, 32'h0000_2635);
    settle();
    chk({26'h0, portDataDir, aSecond}, {26'h0, 4'b0111, 2'b10},
      "mixed modes");
    HOST.set_reset(1'b0);
    settle();
    chk({31'h0, chipResetN}, 32'h0000_0001, "chip run");
    $display("test ports done");
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    test_regs();
    test_decode();
    test_bank();
    test_irq();
    test_ports();
    finish_test();
  end
endmodule // tb_top
